// ---- vdec_pkg.sv ----
// Purpose: shared constants and types for the guest virtualization opcode decoder
// Assumes: 32-bit instruction words, one core clock, synchronous active-high reset
// Notes: all encodings below are field values of the instruction word
// How it works
// - config word three carries virt present flag
// - reserved codes raise reserved-instruction
// - higher-level encodings raise reserved-instruction
// - partner codes: reserved or coprocessor-unusable
// - optional debug return, reserved when absent
// - absent extension module codes raise reserved-instruction
// - field class codes decode a further field
// - major opcode 010000 selects system coprocessor
// - source field selects moves, guest, system op
// - guest class: 000 read, 010 write
// - row 000: root translation entry operations
// - row 001/010: root probe, guest operations
// - exception return, debug return, wait decode
// - hypervisor call; rows 110, 111 reserved
// - privileged op in unprivileged mode traps
package vdec_pkg;

    // major opcode field
    localparam int OP_MSB = 31;
    localparam int OP_LSB = 26;
    localparam logic [5:0] OPC_SYS_COP = 6'h10;
    // register-source field
    localparam int RS_MSB = 25;
    localparam int RS_LSB = 21;
    localparam logic [4:0] RS_MOVE_FROM = 5'h00;
    localparam logic [4:0] RS_GUEST = 5'h03;
    localparam logic [4:0] RS_MOVE_TO = 5'h04;
    localparam logic [1:0] RS_ROW_RESV = 2'h1;
    localparam logic [1:0] RS_ROW_SYSOP = 2'h3;
    // guest-transfer sub-function, bits 10..8
    localparam int GF_MSB = 10;
    localparam int GF_LSB = 8;
    localparam logic [2:0] GF_MOVE_FROM = 3'h0;
    localparam logic [2:0] GF_MOVE_TO = 3'h2;
    // system-op function field bits 5..0
    localparam int FN_MSB = 5;
    localparam int FN_LSB = 0;
    localparam logic [5:0] FN_RX_READ = 6'h01;
    localparam logic [5:0] FN_RX_WR_IDX = 6'h02;
    localparam logic [5:0] FN_RX_INV = 6'h03;
    localparam logic [5:0] FN_RX_FLINV = 6'h04;
    localparam logic [5:0] FN_RX_WR_RND = 6'h06;
    localparam logic [5:0] FN_RX_PROBE = 6'h08;
    localparam logic [5:0] FN_GX_READ = 6'h09;
    localparam logic [5:0] FN_GX_WR_IDX = 6'h0A;
    localparam logic [5:0] FN_GX_INV = 6'h0B;
    localparam logic [5:0] FN_GX_FLINV = 6'h0C;
    localparam logic [5:0] FN_GX_WR_RND = 6'h0E;
    localparam logic [5:0] FN_GX_PROBE = 6'h10;
    localparam logic [5:0] FN_EXC_RET = 6'h18;
    localparam logic [5:0] FN_DBG_RET = 6'h1F;
    localparam logic [5:0] FN_WAIT = 6'h20;
    localparam logic [5:0] FN_HYPERVISOR_CALL_CODE = 6'h28;
    // presence flag bit position in config word three
    localparam int CFG3_VIRT_BIT = 23;

    // one-hot operation index
    typedef enum logic [4:0] {
        OP_MOVE_FROM_SYS, OP_MOVE_TO_SYS, OP_MOVE_FROM_GUEST, OP_MOVE_TO_GUEST,
        OP_RX_READ, OP_RX_WR_IDX, OP_RX_INV, OP_RX_FLINV, OP_RX_WR_RND, OP_RX_PROBE,
        OP_GX_READ, OP_GX_WR_IDX, OP_GX_INV, OP_GX_FLINV, OP_GX_WR_RND, OP_GX_PROBE,
        OP_EXC_RET, OP_DBG_RET, OP_WAIT, OP_HYPER_CALL, OP_COUNT
    } op_idx_e;
    localparam int NUM_OPS = 20;
    typedef logic [NUM_OPS-1:0] op_sel_t;

    // decode result
    typedef struct packed {
        op_sel_t op_sel;
        logic resv_instr;
        logic cop_unusable;
        logic priv_trap;
        logic is_sys_cop;
    } dec_res_s;

endpackage

// ---- vdec_table.sv ----
// Purpose: combinational lookup of the system-coprocessor encoding tables
// Assumes: caller gates by the system-coprocessor major opcode
// Notes: pure logic, no state
`timescale 1ns/100ps
`default_nettype none
module vdec_table (
    // instruction and options
    input wire logic [31:0] instr_i,
    input wire logic debug_impl_i,
    // classification
    output logic [vdec_pkg::NUM_OPS-1:0] op_sel_o,
    output logic reserved_o
);
    import vdec_pkg::*;

    logic [4:0] rs;     // register-source field
    logic [2:0] gfn;    // guest sub-function
    logic [5:0] fn;     // system-op function

    // field class codes always go one table deeper before naming an op
    always_comb begin
        rs = instr_i[RS_MSB:RS_LSB];
        gfn = instr_i[GF_MSB:GF_LSB];
        fn = instr_i[FN_MSB:FN_LSB];
        op_sel_o = '0;
        reserved_o = 1'b0;
        if (rs == RS_MOVE_FROM) begin
            op_sel_o[OP_MOVE_FROM_SYS] = 1'b1;
        end else if (rs == RS_MOVE_TO) begin
            op_sel_o[OP_MOVE_TO_SYS] = 1'b1;
        end else if (rs == RS_GUEST) begin
            case (gfn)
                GF_MOVE_FROM: op_sel_o[OP_MOVE_FROM_GUEST] = 1'b1;
                GF_MOVE_TO: op_sel_o[OP_MOVE_TO_GUEST] = 1'b1;
                // odd codes are higher-level, 100..111 held back
                default: reserved_o = 1'b1;
            endcase
        end else if (rs[4:3] == RS_ROW_SYSOP) begin
            case (fn)
                FN_RX_READ: op_sel_o[OP_RX_READ] = 1'b1;
                FN_RX_WR_IDX: op_sel_o[OP_RX_WR_IDX] = 1'b1;
                FN_RX_INV: op_sel_o[OP_RX_INV] = 1'b1;
                FN_RX_FLINV: op_sel_o[OP_RX_FLINV] = 1'b1;
                FN_RX_WR_RND: op_sel_o[OP_RX_WR_RND] = 1'b1;
                FN_RX_PROBE: op_sel_o[OP_RX_PROBE] = 1'b1;
                FN_GX_READ: op_sel_o[OP_GX_READ] = 1'b1;
                FN_GX_WR_IDX: op_sel_o[OP_GX_WR_IDX] = 1'b1;
                FN_GX_INV: op_sel_o[OP_GX_INV] = 1'b1;
                FN_GX_FLINV: op_sel_o[OP_GX_FLINV] = 1'b1;
                FN_GX_WR_RND: op_sel_o[OP_GX_WR_RND] = 1'b1;
                FN_GX_PROBE: op_sel_o[OP_GX_PROBE] = 1'b1;
                FN_EXC_RET: op_sel_o[OP_EXC_RET] = 1'b1;
                FN_WAIT: op_sel_o[OP_WAIT] = 1'b1;
                FN_HYPERVISOR_CALL_CODE: op_sel_o[OP_HYPER_CALL] = 1'b1;
                FN_DBG_RET: begin
                    // optional debug return sits only at its listed slot
                    if (debug_impl_i) begin
                        op_sel_o[OP_DBG_RET] = 1'b1;
                    end else begin
                        reserved_o = 1'b1;
                    end
                end
                // every other column, and rows 110/111, is held back
                default: reserved_o = 1'b1;
            endcase
        end else begin
            // row 01, higher-level and held-back codes of row 00, and row 10
            reserved_o = 1'b1;
        end
    end

endmodule
`default_nettype wire

// ---- vdec_top.sv ----
// Purpose: guest virtualization opcode decoder top level
// Assumes: fetch presents one instruction word per cycle with a valid strobe
// Notes: decode is combinational; only the presence strap path is held in flops
`timescale 1ns/100ps
`default_nettype none
module guest_virt_opcode_decoder (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // instruction from fetch
    input wire logic [31:0] instr_i,
    input wire logic instr_valid_i,
    // core state
    input wire logic priv_mode_i,
    input wire logic cop_access_ok_i,
    input wire logic debug_impl_i,
    input wire logic virt_impl_i,
    // decode result
    output vdec_pkg::dec_res_s dec_o,
    output logic dec_valid_o,
    // configuration word three, presence flag only
    output logic [31:0] config_word_three_o,
    output logic virt_present_flag_o
);
    import vdec_pkg::*;

    // ops that only the extension defines; decode and checks share this list
    function automatic op_sel_t module_ops();
        op_sel_t m;
        m = '0;
        m[OP_MOVE_FROM_GUEST] = 1'b1;
        m[OP_MOVE_TO_GUEST] = 1'b1;
        m[OP_GX_READ] = 1'b1;
        m[OP_GX_WR_IDX] = 1'b1;
        m[OP_GX_INV] = 1'b1;
        m[OP_GX_FLINV] = 1'b1;
        m[OP_GX_WR_RND] = 1'b1;
        m[OP_GX_PROBE] = 1'b1;
        m[OP_HYPER_CALL] = 1'b1;
        return m;
    endfunction

    // root ops stay usable on a core built without the extension
    localparam op_sel_t MODULE_OPS = module_ops();

    op_sel_t tbl_sel;       // table lookup select
    logic tbl_resv;         // table lookup reserved
    logic is_sys;           // major opcode hit
    logic virt_r;           // presence flag, caught after reset
    logic virt_nxt;
    logic [2:0] virt_sync_r;    // strap synchroniser, stage 0 meets the pin
    logic [2:0] virt_sync_nxt;
    op_sel_t mod_hit;           // table picked an op that only the extension defines
    dec_res_s res;

    // encoding tables
    vdec_table u_table (
        .instr_i(instr_i),
        .debug_impl_i(debug_impl_i),
        .op_sel_o(tbl_sel),
        .reserved_o(tbl_resv)
    );

    // the strap is a pin, so it crosses three stages before it is believed;
    // the stages carry no reset, so a steady strap has settled by the time
    // reset lifts and the flag is right on the first edge after release
    always_comb begin
        virt_sync_nxt = {virt_sync_r[1:0], virt_impl_i};
        if (virt_sync_r[1] == virt_sync_r[2]) begin
            // last two stages agree: take the new level
            virt_nxt = virt_sync_r[2];
        end else begin
            // still settling: keep what was believed, a one-cycle glitch never shows
            virt_nxt = virt_r;
        end
    end

    // synchroniser stages, registered only
    always_ff @(posedge core_clk_i) begin
        virt_sync_r <= virt_sync_nxt;
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            virt_r <= 1'b0;
        end else begin
            virt_r <= virt_nxt;
        end
    end

    // the flag sits in its own bit, other bits of the word read zero
    always_comb begin
        config_word_three_o = '0;
        config_word_three_o[CFG3_VIRT_BIT] = virt_r;
        virt_present_flag_o = virt_r;
    end

    // classify in the same cycle the word arrives
    always_comb begin
        is_sys = (instr_i[OP_MSB:OP_LSB] == OPC_SYS_COP);
        res = '0;
        mod_hit = tbl_sel & MODULE_OPS;
        res.is_sys_cop = is_sys;
        if (instr_valid_i && is_sys) begin
            if (!cop_access_ok_i || !priv_mode_i) begin
                // unprivileged or denied access traps before any table lookup
                res.cop_unusable = 1'b1;
                res.priv_trap = !priv_mode_i;
            end else if (!virt_r && mod_hit != '0) begin
                // extension absent: its own codes are refused, base ops still decode
                res.resv_instr = 1'b1;
            end else begin
                res.op_sel = tbl_sel;
                res.resv_instr = tbl_resv;
            end
        end
        dec_o = res;
        dec_valid_o = instr_valid_i;
    end

    // properties on the decoder
    onehot_sel_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $onehot0(dec_o.op_sel)) else $error("op select not one-hot");
    resv_excl_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.resv_instr |-> dec_o.op_sel == '0) else $error("reserved with op");
    trap_unpriv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (instr_valid_i && is_sys && !priv_mode_i) |-> dec_o.cop_unusable)
        else $error("no trap in unprivileged mode");
    sysop_hit_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel != '0 |-> instr_i[OP_MSB:OP_LSB] == OPC_SYS_COP)
        else $error("op outside system opcode");
    row01_resv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (instr_valid_i && is_sys && priv_mode_i && cop_access_ok_i && virt_r
         && instr_i[RS_MSB-:2] == RS_ROW_RESV) |-> dec_o.resv_instr)
        else $error("row 01 not reserved");
    hyp_call_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_HYPER_CALL] |-> instr_i[FN_MSB:FN_LSB] == FN_HYPERVISOR_CALL_CODE)
        else $error("hypervisor call wrong code");
    guest_mv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_MOVE_TO_GUEST] |-> instr_i[GF_MSB:GF_LSB] == GF_MOVE_TO)
        else $error("guest move code wrong");
    dbg_opt_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_DBG_RET] |-> debug_impl_i) else $error("debug return absent");
    // a strap level that stood through the synchroniser shows up one edge later
    flag_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!$past(rst_i) && $past(virt_impl_i, 3) == $past(virt_impl_i, 4))
        |-> virt_present_flag_o == $past(virt_impl_i, 4)) else $error("flag lag wrong");
    absent_resv_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (!virt_r && dec_o.op_sel != '0) |-> (dec_o.op_sel & MODULE_OPS) == '0)
        else $error("absent module op selected");
    absent_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (instr_valid_i && is_sys && priv_mode_i && cop_access_ok_i && !virt_r
         && mod_hit != '0) |-> (dec_o.resv_instr && dec_o.op_sel == '0))
        else $error("absent module not reserved");

    // these selects only rise on their own slots of the tables
    mv_from_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_MOVE_FROM_SYS] |-> instr_i[RS_MSB:RS_LSB] == RS_MOVE_FROM)
        else $error("move from system wrong code");
    guest_from_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_MOVE_FROM_GUEST] |-> instr_i[GF_MSB:GF_LSB] == GF_MOVE_FROM)
        else $error("guest read code wrong");
    root_read_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_RX_READ] |-> (instr_i[RS_MSB-:2] == RS_ROW_SYSOP
        && instr_i[FN_MSB:FN_LSB] == FN_RX_READ)) else $error("root read wrong code");
    rx_probe_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_RX_PROBE] |-> instr_i[FN_MSB:FN_LSB] == FN_RX_PROBE)
        else $error("root probe wrong code");
    guest_probe_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_GX_PROBE] |-> instr_i[FN_MSB:FN_LSB] == FN_GX_PROBE)
        else $error("guest probe wrong code");
    exc_ret_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_EXC_RET] |-> instr_i[FN_MSB:FN_LSB] == FN_EXC_RET)
        else $error("exception return wrong code");
    wait_code_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_o.op_sel[OP_WAIT] |-> instr_i[FN_MSB:FN_LSB] == FN_WAIT)
        else $error("wait wrong code");

    // refusals: held-back rows, missing debug return, denied access, idle slots; no trap when privileged
    high_rows_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (instr_valid_i && is_sys && priv_mode_i && cop_access_ok_i
         && instr_i[RS_MSB-:2] == RS_ROW_SYSOP && &instr_i[FN_MSB-:2])
        |-> dec_o.resv_instr) else $error("high function rows not reserved");
    dbg_absent_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (instr_valid_i && is_sys && priv_mode_i && cop_access_ok_i && !debug_impl_i
         && instr_i[RS_MSB-:2] == RS_ROW_SYSOP && instr_i[FN_MSB:FN_LSB] == FN_DBG_RET)
        |-> dec_o.resv_instr) else $error("absent debug return not reserved");
    access_deny_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (instr_valid_i && is_sys && !cop_access_ok_i) |-> (dec_o.cop_unusable
        && dec_o.op_sel == '0 && !dec_o.resv_instr)) else $error("denied access decoded");
    idle_quiet_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !instr_valid_i |-> (dec_o.op_sel == '0 && !dec_o.resv_instr
        && !dec_o.cop_unusable)) else $error("idle slot decoded");
    priv_quiet_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (instr_valid_i && is_sys && priv_mode_i) |-> !dec_o.priv_trap)
        else $error("trap in privileged mode");

    wait_c: cover property (@(posedge core_clk_i) dec_o.op_sel[OP_WAIT]);
    gprobe_c: cover property (@(posedge core_clk_i) dec_o.op_sel[OP_GX_PROBE]);
    resv_c: cover property (@(posedge core_clk_i) dec_o.resv_instr);
    unus_c: cover property (@(posedge core_clk_i) dec_o.cop_unusable);
    absent_c: cover property (@(posedge core_clk_i) !virt_r && dec_o.op_sel != '0);

endmodule
`default_nettype wire

// ---- fetch_model.sv ----
// Purpose: behavioural fetch stage feeding words and core state to the decoder
// Assumes: caller times each issue just after a rising core clock edge
// Notes: an idle slot shows the inverse of the last word, so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
    // fetch side
    output var logic [31:0] instr_o,
    output var logic valid_o,
    // core state
    output var logic priv_o,
    output var logic access_o,
    output var logic debug_o
);
    // quiet, privileged start so nothing traps before the first issue
    initial begin
        instr_o = 32'h0000_0000;
        valid_o = 1'b0;
        priv_o = 1'b1;
        access_o = 1'b1;
        debug_o = 1'b0;
    end

    // one slot; a real fetch would avoid obsolete codes, this one only sends what it is told
    task automatic issue(input logic [31:0] w, input logic v, p, a, d);
        instr_o = v ? w : ~instr_o;
        valid_o = v;
        priv_o = p;
        access_o = a;
        debug_o = d;
    endtask
endmodule
`default_nettype wire

// ---- guest_virt_opcode_decoder_tb.sv ----
// Purpose: self-checking bench for the guest virtualization opcode decoder
// Assumes: same-cycle decode; presence flag loads on the first edge after reset
// Notes: the driver queues masked expectations, a falling-edge monitor retires them
`timescale 1ns/100ps
`default_nettype none
module guest_virt_opcode_decoder_tb;
    import vdec_pkg::*;
    localparam int W = $bits(dec_res_s);
    // row 000 to 101 codes in select order, read..hypervisor call
    localparam logic [5:0] FN_TAB [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08,
        6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0E, 6'h10, 6'h18, 6'h1F, 6'h20, 6'h28};
    logic core_clk_i; // core clock
    logic rst_i; // sync reset
    logic virt_impl_i; // extension strap
    logic pres; // flag the bench expects
    wire [31:0] instr_w;
    wire valid_w, priv_w, acc_w, dbg_w;
    dec_res_s dec_o;
    logic dec_valid_o;
    logic [31:0] config_word_three_o;
    logic virt_present_flag_o;
    logic [2*W:0] q [$]; // {valid, mask, value}
    logic [2*W:0] note;
    logic [31:0] w, r;
    int seed, err_count, checked;

    fetch_model u_fetch (.instr_o(instr_w), .valid_o(valid_w), .priv_o(priv_w),
        .access_o(acc_w), .debug_o(dbg_w));
    guest_virt_opcode_decoder dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .instr_i(instr_w),
        .instr_valid_i(valid_w), .priv_mode_i(priv_w), .cop_access_ok_i(acc_w),
        .debug_impl_i(dbg_w), .virt_impl_i(virt_impl_i), .dec_o(dec_o),
        .dec_valid_o(dec_valid_o), .config_word_three_o(config_word_three_o),
        .virt_present_flag_o(virt_present_flag_o));

    task automatic check(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("checked %0d err_count %0d", checked, err_count);
        if (checked > 0 && err_count == 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // reference decode; a denial only pins the flags it defines, every other case is checked in full
    function automatic logic [2*W:0] expect_dec(input logic [31:0] x, input logic v, p, a, d);
        dec_res_s e;
        dec_res_s m;
        int k;
        e = '0;
        m = '1;
        k = -1;
        e.is_sys_cop = (x[31:26] == 6'h10);
        if (!v || !e.is_sys_cop) return {v, m, e};
        if (!p || !a) begin
            m = '0;
            {m.cop_unusable, m.priv_trap} = 2'h3;
            {e.cop_unusable, e.priv_trap} = {1'b1, !p};
            return {v, m, e};
        end
        if (x[25:21] == 5'h00) k = OP_MOVE_FROM_SYS;
        if (x[25:21] == 5'h04) k = OP_MOVE_TO_SYS;
        if (x[25:21] == 5'h03 && x[10:8] == 3'h0) k = OP_MOVE_FROM_GUEST;
        if (x[25:21] == 5'h03 && x[10:8] == 3'h2) k = OP_MOVE_TO_GUEST;
        for (int j = 0; j < 16; j++) begin
            if (x[25:24] == 2'h3 && x[5:0] == FN_TAB[j]) k = OP_RX_READ + j;
        end
        if (k == OP_DBG_RET && !d) k = -1;
        // with the extension strapped off only its own codes are refused
        if (!pres && (k == OP_MOVE_FROM_GUEST || k == OP_MOVE_TO_GUEST
            || k == OP_HYPER_CALL || (k >= OP_GX_READ && k <= OP_GX_PROBE))) k = -1;
        if (k < 0) e.resv_instr = 1'b1;
        else e.op_sel[k] = 1'b1;
        return {v, m, e};
    endfunction

    task automatic send(input logic [31:0] x, input logic v, p, a, d);
        @(posedge core_clk_i);
        #1;
        u_fetch.issue(x, v, p, a, d);
        q.push_back(expect_dec(u_fetch.instr_o, v, p, a, d));
    endtask

    // decode is same-cycle, so the falling edge sees the settled answer
    always @(negedge core_clk_i) begin
        if (q.size() > 0) begin
            note = q.pop_front();
            check("dec_o", {dec_valid_o, dec_o & note[2*W-1:W]}, {note[2*W], note[W-1:0] & note[2*W-1:W]});
        end
    end

    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    // watchdog, several times the expected run
    initial begin
        repeat (4000) @(posedge core_clk_i);
        err_count++;
        test_done;
    end

    initial begin
        seed = 32'h6B08D115;
        rst_i = 1'b1;
        virt_impl_i = 1'b1;
        pres = 1'b1;
        repeat (6) @(posedge core_clk_i);
        #1;
        check("cfg_rst", config_word_three_o, 32'h0000_0000);
        rst_i = 1'b0;
        @(posedge core_clk_i);
        #1;
        check("cfg", config_word_three_o, 32'h0080_0000);
        check("flag", {31'h0, virt_present_flag_o}, 32'h1);
        // every register-source code, back to back
        for (int i = 0; i < 32; i++) send({6'h10, i[4:0], 15'h0, 6'h18}, 1, 1, 1, 1);
        // every function code, with and without debug return
        for (int i = 0; i < 128; i++) send({6'h10, 5'h18, 15'h0, i[5:0]}, 1, 1, 1, i[6]);
        // every guest sub-function code
        for (int i = 0; i < 8; i++) send({6'h10, 5'h03, 10'h0, i[2:0], 8'h0}, 1, 1, 1, 1);
        // random words, idle slots, privilege and access denials
        for (int i = 0; i < 400; i++) begin
            w = $random(seed);
            r = $random(seed);
            if (r[7] | r[8]) w[31:26] = 6'h10;
            send(w, r[0] | r[1], r[2] | r[3], r[4] | r[5], r[6]);
        end
        // second reset with the extension strapped off
        @(posedge core_clk_i);
        #1;
        rst_i = 1'b1;
        virt_impl_i = 1'b0;
        pres = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        rst_i = 1'b0;
        @(posedge core_clk_i);
        #1;
        check("cfg_off", config_word_three_o, 32'h0000_0000);
        check("flag_off", {31'h0, virt_present_flag_o}, 32'h0);
        // a base move still decodes, a hypervisor call is refused
        send({6'h10, 5'h00, 21'h0}, 1, 1, 1, 1);
        send({6'h10, 5'h18, 15'h0, 6'h28}, 1, 1, 1, 1);
        for (int i = 0; i < 8; i++) begin
            w = $random(seed);
            send({6'h10, w[25:0]}, 1, 1, 1, 1);
        end
        repeat (2) @(posedge core_clk_i);
        test_done;
    end
endmodule
`default_nettype wire
